// [logic/dcps_sequencer.sv]
// Device-side reply sequencer for command-mode link traffic
// How it works
// R01: One-byte generic read reply uses data type 11h.
// R02: Two-byte generic read reply uses data type 12h with both bytes.
// R03: Identifier holds channel in top two bits, type in low six.
// R04: One-byte replies send the byte first and 00h second.
// R05: Replies go only to the host, only after a read request.
// R06: Lane actions: stop, LP data, ULPS, reset, tearing, ack, turnaround, HS data. The sequencer drives only stop, LP data, ack and turnaround.
// R07: Host sends write, read and size commands as short or long packets.
// R08: Error report and short replies are short packets; long reply is long.
// R09: Low-power write is one packet then stop, no end packet.
// R10: High-speed writes end with an end packet, then stop.
// R11: Host turns the bus over; device holds stop before replying.
// R12: No error: device sends acknowledge then returns to stop.
// R13: Error: device sends error report packet then returns to stop.
// R14: After replying, device turns the bus back to the host.
// R15: Memory write burst starts 2Ch, continues 3Ch, closes with end packet.
// R16: Host sets maximum return size before a no-parameter read.
// R17: Only data lanes are sequenced; clock lane is automatic.
// R18: Clean read: reply in LP data, stop, then turn the bus back.
// R19: ECC-corrected read: reply, then error report, then stop.
// R20: Device appends Hamming ECC over identifier and payload.
// R21: Host drives the lane only while it owns it.
`timescale 1ns/1ps
module dcps_sequencer
  import dcps_pkg::*;
#(
  parameter int HOLD_CYC = LP11_HOLD_CYC
) (
  input wire logic sys_clk, // System clock
  input wire logic resetn, // Async reset, active low
  input wire logic link_clk, // Link-side clock
  input wire logic req_valid, // Link domain: request decoded (pulse)
  input wire dcps_req_info_type req_info, // Link domain: request details
  input wire logic bta_in, // Link domain: host turnaround done (pulse)
  input wire logic long_done, // Long reply body sent by payload path
  output dcps_lane_type lane_state, // Lane action being driven
  output logic lane_owned, // Device owns the data lane
  output logic pkt_valid, // Short packet presented
  output dcps_short_type pkt_out, // Short packet bytes
  output logic long_start, // Start long reply header (pulse)
  output dcps_short_type long_hdr, // Long reply header
  output logic bta_out // Device turnaround to host (pulse)
);
  initial begin
    if (HOLD_CYC < 1) begin
      $error("HOLD_CYC must be at least one");
    end
    if (HOLD_CYC > 256) begin
      $error("HOLD_CYC must fit the 8-bit hold counter");
    end
  end

  typedef enum logic [3:0] {
    ST_IDLE, ST_HOLD, ST_REPLY, ST_LONG, ST_REPORT, ST_ACK, ST_STOP, ST_BTA
  } dcps_state_type;

  function automatic logic [7:0] make_ident(input logic [5:0] dt);
    make_ident = {VC_DEFAULT, dt}; // see R03
  endfunction

  // Link domain: capture request and turnaround as toggles
  logic req_tgl_reg, req_tgl_next;
  logic bta_tgl_reg, bta_tgl_next;
  dcps_req_info_type info_reg, info_next;
  always_comb begin
    req_tgl_next = req_tgl_reg;
    bta_tgl_next = bta_tgl_reg;
    info_next = info_reg;
    if (req_valid) begin
      req_tgl_next = ~req_tgl_reg;
      info_next = req_info;
    end
    if (bta_in) begin
      bta_tgl_next = ~bta_tgl_reg;
    end
  end
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      req_tgl_reg <= 1'b0;
      bta_tgl_reg <= 1'b0;
      info_reg <= '{REQ_WRITE, RESET_BYTE, RESET_BYTE, 1'b0, 1'b0};
    end else begin
      req_tgl_reg <= req_tgl_next;
      bta_tgl_reg <= bta_tgl_next;
      info_reg <= info_next;
    end
  end

  // System domain synchronisers; info is stable long before the toggle lands
  logic [2:0] req_sync_reg, bta_sync_reg;
  logic [2:0] req_sync_next, bta_sync_next;
  always_comb begin
    req_sync_next = {req_sync_reg[1:0], req_tgl_reg};
    bta_sync_next = {bta_sync_reg[1:0], bta_tgl_reg};
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      req_sync_reg <= 3'b000;
      bta_sync_reg <= 3'b000;
    end else begin
      req_sync_reg <= req_sync_next;
      bta_sync_reg <= bta_sync_next;
    end
  end
  logic req_event, bta_event;
  assign req_event = req_sync_reg[2] ^ req_sync_reg[1];
  assign bta_event = bta_sync_reg[2] ^ bta_sync_reg[1];

  // Request is latched in system domain once the toggle has settled
  dcps_req_info_type held_reg, held_next;
  logic pending_reg, pending_next;
  dcps_state_type state_reg, state_next;
  logic [7:0] cnt_reg, cnt_next;
  logic [23:0] hdr;
  logic [7:0] ecc;
  logic [23:0] ecc_word;
  dcps_short_type pkt_reg, pkt_next;
  logic pkt_valid_reg, pkt_valid_next;
  logic long_start_reg, long_start_next;
  logic bta_out_reg, bta_out_next;

  // Parity counts the identifier as bits 0 to 7, the first byte on the wire
  assign ecc_word = {hdr[7:0], hdr[15:8], hdr[23:16]}; // see R20
  dcps_ecc u_ecc (
    .hdr(ecc_word),
    .ecc(ecc)
  );

  function automatic logic is_read(input dcps_req_type k);
    is_read = (k != REQ_WRITE);
  endfunction

  // Reply header build: type and payload by request kind
  logic [5:0] reply_dt;
  logic [7:0] reply_d0, reply_d1;
  always_comb begin
    reply_d0 = held_reg.data0;
    reply_d1 = held_reg.data1;
    case (held_reg.kind)
      REQ_GEN_READ_ONE: begin
        reply_dt = DT_GEN_REPLY_ONE; // see R01
        reply_d1 = PAYLOAD_PAD; // see R04
      end
      REQ_GEN_READ_TWO: begin
        reply_dt = DT_GEN_REPLY_TWO; // see R02
      end
      REQ_CMD_READ_ONE: begin
        reply_dt = DT_CMD_REPLY_ONE;
        reply_d1 = PAYLOAD_PAD; // see R04
      end
      REQ_CMD_READ_TWO: begin
        reply_dt = DT_CMD_REPLY_TWO;
      end
      REQ_CMD_READ_LONG: begin
        reply_dt = DT_CMD_REPLY_LONG; // see R08
      end
      default: begin
        reply_dt = DT_ACK_ERR_REPORT;
      end
    endcase
    if (state_reg == ST_REPORT || state_reg == ST_HOLD) begin
      hdr = {make_ident(DT_ACK_ERR_REPORT), PAYLOAD_PAD, PAYLOAD_PAD};
    end else begin
      hdr = {make_ident(reply_dt), reply_d0, reply_d1};
    end
  end

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    held_next = held_reg;
    pending_next = pending_reg;
    pkt_next = pkt_reg;
    pkt_valid_next = 1'b0;
    long_start_next = 1'b0;
    bta_out_next = 1'b0;
    if (req_event) begin
      held_next = info_reg;
      pending_next = 1'b1;
    end
    case (state_reg)
      ST_IDLE: begin
        if (bta_event) begin
          state_next = ST_HOLD; // see R11
          cnt_next = 8'(HOLD_CYC - 1);
        end
      end
      ST_HOLD: begin
        if (cnt_reg != 8'h00) begin
          cnt_next = cnt_reg - 8'h01;
        end else if (pending_reg && is_read(held_reg.kind) && !held_reg.err_seen) begin
          state_next = (held_reg.kind == REQ_CMD_READ_LONG) ? ST_LONG : ST_REPLY; // see R05
        end else if (pending_reg && held_reg.err_seen) begin
          state_next = ST_REPORT; // see R13
        end else begin
          state_next = ST_ACK; // see R12
        end
      end
      ST_REPLY: begin
        pkt_valid_next = 1'b1; // see R18
        pkt_next = '{hdr[23:16], hdr[15:8], hdr[7:0], ecc}; // see R20
        state_next = held_reg.err_fixed ? ST_REPORT : ST_STOP; // see R19
      end
      ST_LONG: begin
        if (cnt_reg == 8'h00) begin
          long_start_next = 1'b1;
          pkt_next = '{hdr[23:16], hdr[15:8], hdr[7:0], ecc}; // see R08
          cnt_next = 8'h01;
        end else if (long_done) begin
          state_next = held_reg.err_fixed ? ST_REPORT : ST_STOP; // see R19
        end
      end
      ST_REPORT: begin
        // Always sent here, also after a corrected-error reply
        pkt_valid_next = 1'b1; // see R13 see R19
        pkt_next = '{hdr[23:16], hdr[15:8], hdr[7:0], ecc};
        state_next = ST_STOP;
      end
      ST_ACK: begin
        state_next = ST_STOP; // see R12
      end
      ST_STOP: begin
        state_next = ST_BTA;
        // A request landing now is kept rather than lost
        pending_next = req_event;
      end
      ST_BTA: begin
        bta_out_next = 1'b1; // see R14
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 8'h00;
      held_reg <= '{REQ_WRITE, RESET_BYTE, RESET_BYTE, 1'b0, 1'b0};
      pending_reg <= 1'b0;
      pkt_reg <= '{RESET_BYTE, RESET_BYTE, RESET_BYTE, RESET_BYTE};
      pkt_valid_reg <= 1'b0;
      long_start_reg <= 1'b0;
      bta_out_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      held_reg <= held_next;
      pending_reg <= pending_next;
      pkt_reg <= pkt_next;
      pkt_valid_reg <= pkt_valid_next;
      long_start_reg <= long_start_next;
      bta_out_reg <= bta_out_next;
    end
  end

  // Lane action follows the state; clock lane is left to the PHY
  always_comb begin
    case (state_reg)
      ST_REPLY, ST_LONG, ST_REPORT: lane_state = LANE_LPDT; // see R17
      ST_ACK: lane_state = LANE_ACK; // see R06
      ST_BTA: lane_state = LANE_BTA;
      default: lane_state = LANE_STOP;
    endcase
  end
  assign lane_owned = (state_reg != ST_IDLE);
  assign pkt_valid = pkt_valid_reg;
  assign pkt_out = pkt_reg;
  assign long_start = long_start_reg;
  assign long_hdr = pkt_reg;
  assign bta_out = bta_out_reg;

  sequence s_reply_then_stop;
    (state_reg == ST_REPLY) ##1 pkt_valid;
  endsequence

  chk_one_byte_pad: assert property (@(posedge sys_clk) disable iff (!resetn) // see R04
    (pkt_valid && pkt_out.ident[5:0] == DT_GEN_REPLY_ONE) |-> pkt_out.data1 == PAYLOAD_PAD)
    else $error("one byte reply second byte not zero");
  chk_ident_channel: assert property (@(posedge sys_clk) disable iff (!resetn) // see R03
    pkt_valid |-> pkt_out.ident[7:DI_VC_POS] == VC_DEFAULT)
    else $error("reply channel not zero");
  chk_reply_needs_read: assert property (@(posedge sys_clk) disable iff (!resetn) // see R05
    (state_reg == ST_REPLY) |-> (pending_reg && is_read(held_reg.kind)))
    else $error("reply without read request");
  chk_reply_stop_bta: assert property (@(posedge sys_clk) disable iff (!resetn) // see R18
    s_reply_then_stop |-> ##[1:2] (lane_state == LANE_BTA))
    else $error("reply not followed by turnaround");
  chk_ack_then_stop: assert property (@(posedge sys_clk) disable iff (!resetn) // see R12
    (lane_state == LANE_ACK) |=> (lane_state == LANE_STOP) ##1 (lane_state == LANE_BTA) ##1 bta_out)
    else $error("ack not followed by stop and turnaround");
  chk_hold_before_reply: assert property (@(posedge sys_clk) disable iff (!resetn) // see R11
    (state_reg == ST_IDLE && bta_event) |=> (lane_state == LANE_STOP && lane_owned) [*1])
    else $error("no stop hold after turnaround");
  chk_error_report: assert property (@(posedge sys_clk) disable iff (!resetn) // see R13
    (state_reg == ST_REPORT) |-> ##[0:1] (pkt_valid && pkt_out.ident[5:0] == DT_ACK_ERR_REPORT))
    else $error("error report missing");
  chk_fixed_report: assert property (@(posedge sys_clk) disable iff (!resetn) // see R19
    (state_reg == ST_REPLY && held_reg.err_fixed) |=> (state_reg == ST_REPORT))
    else $error("corrected error not reported");
  chk_two_byte_type: assert property (@(posedge sys_clk) disable iff (!resetn) // see R02
    (state_reg == ST_REPLY && held_reg.kind == REQ_GEN_READ_TWO) |=> pkt_out.ident == 8'h12)
    else $error("two byte reply type wrong");
  chk_one_byte_type: assert property (@(posedge sys_clk) disable iff (!resetn) // see R01
    (state_reg == ST_REPLY && held_reg.kind == REQ_GEN_READ_ONE) |=> pkt_out.ident == 8'h11)
    else $error("one byte reply type wrong");
  chk_bta_returns: assert property (@(posedge sys_clk) disable iff (!resetn) // see R14
    bta_out |=> (state_reg == ST_IDLE))
    else $error("lane not released after turnaround");
endmodule // dcps_sequencer

// [logic/dcps_pkg.sv]
// Package of constants and types for the command-mode packet sequencer
package dcps_pkg;
  localparam logic [5:0] DT_GEN_REPLY_ONE = 6'h11;
  localparam logic [5:0] DT_GEN_REPLY_TWO = 6'h12;
  localparam logic [5:0] DT_CMD_REPLY_ONE = 6'h21;
  localparam logic [5:0] DT_CMD_REPLY_TWO = 6'h22;
  localparam logic [5:0] DT_CMD_REPLY_LONG = 6'h1C;
  localparam logic [5:0] DT_ACK_ERR_REPORT = 6'h02;
  localparam logic [1:0] VC_DEFAULT = 2'h0;
  localparam int DI_VC_POS = 6;
  localparam logic [7:0] PAYLOAD_PAD = 8'h00;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // Lane hold before a reply, in ns
  localparam int LP11_HOLD_NS = 100;
  localparam int CLK_PERIOD_NS = 50;
  localparam int LP11_HOLD_CYC = (LP11_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    REQ_WRITE,
    REQ_GEN_READ_ONE,
    REQ_GEN_READ_TWO,
    REQ_CMD_READ_ONE,
    REQ_CMD_READ_TWO,
    REQ_CMD_READ_LONG
  } dcps_req_type;

  typedef enum logic [2:0] {
    LANE_STOP,
    LANE_LPDT,
    LANE_ACK,
    LANE_BTA,
    LANE_ULPS,
    LANE_RESET_TRIG,
    LANE_TEAR_TRIG
  } dcps_lane_type;

  typedef struct packed {
    logic [7:0] ident;
    logic [7:0] data0;
    logic [7:0] data1;
    logic [7:0] ecc;
  } dcps_short_type;

  typedef struct packed {
    dcps_req_type kind;
    logic [7:0] data0;
    logic [7:0] data1;
    logic err_seen;
    logic err_fixed;
  } dcps_req_info_type;
endpackage

// [logic/dcps_ecc.sv]
// Short-packet header ECC over a 24-bit header
`timescale 1ns/1ps
module dcps_ecc (
  input wire logic [23:0] hdr, // Identifier plus two payload bytes
  output logic [7:0] ecc // Hamming parity byte
);
  always_comb begin
    ecc = 8'h00;
    ecc[0] = ^(hdr & 24'hF1_2CB7); // see R20
    ecc[1] = ^(hdr & 24'hF2_555B);
    ecc[2] = ^(hdr & 24'h74_9A6D);
    ecc[3] = ^(hdr & 24'hB8_E38E);
    ecc[4] = ^(hdr & 24'hDF_03F0);
    ecc[5] = ^(hdr & 24'hEF_FC00);
  end
endmodule // dcps_ecc

// [verif/dcps_host_model.sv]
// Host-side model that issues decoded requests and bus turnarounds
`timescale 1ns/1ps
module dcps_host_model
  import dcps_pkg::*;
(
  input wire logic link_clk, // Link clock
  output logic req_valid, // Request strobe
  output dcps_req_info_type req_info, // Request details
  output logic bta_in // Turnaround to device
);
  initial begin
    req_valid = 1'b0;
    req_info = '0;
    bta_in = 1'b0;
  end
  // Writes and reads all arrive here as one decoded unit
  task automatic send(input dcps_req_info_type info, input bit turn);
    @(posedge link_clk);
    req_valid <= 1'b1;
    req_info <= info;
    @(posedge link_clk);
    req_valid <= 1'b0;
    // Details are stale once the strobe drops, so scramble them
    req_info <= dcps_req_info_type'(~info);
    if (turn) begin
      turn_bus();
    end
  endtask
  // Hand the lane over with a one-cycle bta_in pulse; returns without waiting for the lane back
  task automatic turn_bus();
    @(posedge link_clk);
    bta_in <= 1'b1;
    @(posedge link_clk);
    bta_in <= 1'b0;
  endtask
endmodule // dcps_host_model

// [verif/tb_top.sv]
// Self-checking bench for the command-mode reply sequencer
`timescale 1ns/1ps
module tb_top
  import dcps_pkg::*;
  ;
  typedef struct {
    dcps_req_info_type info;
    logic [5:0] dt1;
    logic ack;
    logic rep;
    logic lng;
  } dcps_row_type;
  logic sys_clk = 1'b0;
  logic link_clk = 1'b0;
  logic resetn = 1'b0;
  logic long_done = 1'b0;
  logic lane_owned, pkt_valid, long_start, bta_out, req_valid, bta_in;
  logic ack_seen, got_long, act_seen, hold_ok;
  dcps_lane_type lane_state;
  dcps_short_type pkt_out, long_hdr, lhdr;
  dcps_req_info_type req_info;
  dcps_short_type q[$];
  dcps_row_type rows[9];
  int n_bta, run, lcnt, cyc, n_fail, n_compared;

  always #25 sys_clk = ~sys_clk;
  always #32 link_clk = ~link_clk;

  dcps_sequencer #(.HOLD_CYC(LP11_HOLD_CYC)) u_dcps_sequencer (.sys_clk(sys_clk), .resetn(resetn),
    .link_clk(link_clk), .req_valid(req_valid), .req_info(req_info), .bta_in(bta_in), .long_done(long_done),
    .lane_state(lane_state), .lane_owned(lane_owned), .pkt_valid(pkt_valid), .pkt_out(pkt_out),
    .long_start(long_start), .long_hdr(long_hdr), .bta_out(bta_out));
  dcps_host_model u_dcps_host_model (.link_clk(link_clk), .req_valid(req_valid), .req_info(req_info),
    .bta_in(bta_in));

  // Own parity model, kept apart from the design's encoder
  function automatic logic [7:0] ecc_of(input logic [23:0] h);
    logic [23:0] m [6];
    ecc_of = 8'h00;
    m = '{24'hF1_2CB7, 24'hF2_555B, 24'h74_9A6D, 24'hB8_E38E, 24'hDF_03F0, 24'hEF_FC00};
    for (int i = 0; i < 6; i++) begin
      ecc_of[i] = ^(h & m[i]);
    end
  endfunction

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (pkt_valid === 1'b1) q.push_back(pkt_out);
    if (lane_state === LANE_ACK) ack_seen <= 1'b1;
    if (bta_out === 1'b1) n_bta <= n_bta + 1;
    if (long_start === 1'b1) begin
      got_long <= 1'b1;
      lhdr <= long_hdr;
    end
    if (lane_owned === 1'b1 && lane_state === LANE_STOP && !act_seen) run <= run + 1;
    if ((lane_state === LANE_LPDT || lane_state === LANE_ACK) && !act_seen) begin
      act_seen <= 1'b1;
      hold_ok <= (run >= LP11_HOLD_CYC);
    end
    // Payload path finishes the long body a few cycles after the header
    if (long_start === 1'b1) lcnt <= 5;
    else if (lcnt != 0) lcnt <= lcnt - 1;
    long_done <= (lcnt == 1);
  end

  task automatic end_of_test();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    if (cyc == 20000) begin
      n_fail++;
      $display("Error at %0t: run timed out", $time);
      end_of_test();
    end
  end

  task automatic compare(input logic ok, input string what);
    n_compared++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask

  task automatic clear();
    q.delete();
    ack_seen = 1'b0;
    got_long = 1'b0;
    act_seen = 1'b0;
    hold_ok = 1'b0;
    run = 0;
  endtask

  task automatic wait_bta(input int b0);
    int k;
    k = 0;
    while (n_bta == b0 && k < 300) begin
      @(posedge sys_clk);
      k++;
    end
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic check_row(input dcps_row_type r);
    int n;
    logic [7:0] d1;
    logic [7:0] di;
    n = int'(r.dt1 != 6'h00) + int'(r.rep);
    d1 = (r.dt1 == DT_GEN_REPLY_ONE || r.dt1 == DT_CMD_REPLY_ONE) ? 8'h00 : r.info.data1;
    di = {2'h0, r.dt1};
    compare(q.size() == n, "reply packet count");
    if (q.size() == n && r.dt1 != 6'h00) begin
      compare(q[0] === {di, r.info.data0, d1, ecc_of({d1, r.info.data0, di})}, "reply packet");
    end
    if (q.size() == n && r.rep) begin
      di = {2'h0, DT_ACK_ERR_REPORT};
      compare(q[n-1] === {di, 16'h0000, ecc_of({16'h0000, di})}, "error report packet");
    end
    compare(ack_seen === r.ack, "acknowledge trigger");
    compare(got_long === r.lng && (!r.lng || lhdr.ident === {2'h0, DT_CMD_REPLY_LONG}), "long reply");
    compare(hold_ok === 1'b1, "stop hold before reply");
    compare(lane_owned === 1'b0 && lane_state === LANE_STOP, "lane not returned");
  endtask

  task automatic run_row(input dcps_row_type r);
    int b0;
    clear();
    b0 = n_bta;
    u_dcps_host_model.send(r.info, 1'b1);
    wait_bta(b0);
    compare(n_bta == b0 + 1, "turnaround back");
    check_row(r);
  endtask

  initial begin
    int b0;
    rows = '{
      '{'{REQ_WRITE, 8'h00, 8'h00, 1'b0, 1'b0}, 6'h00, 1'b1, 1'b0, 1'b0},
      '{'{REQ_GEN_READ_ONE, 8'h45, 8'h5A, 1'b0, 1'b0}, DT_GEN_REPLY_ONE, 1'b0, 1'b0, 1'b0},
      '{'{REQ_GEN_READ_TWO, 8'h45, 8'h32, 1'b0, 1'b0}, DT_GEN_REPLY_TWO, 1'b0, 1'b0, 1'b0},
      '{'{REQ_CMD_READ_ONE, 8'hA7, 8'hFF, 1'b0, 1'b0}, DT_CMD_REPLY_ONE, 1'b0, 1'b0, 1'b0},
      '{'{REQ_CMD_READ_TWO, 8'h01, 8'h80, 1'b0, 1'b0}, DT_CMD_REPLY_TWO, 1'b0, 1'b0, 1'b0},
      '{'{REQ_CMD_READ_LONG, 8'h00, 8'hC8, 1'b0, 1'b0}, 6'h00, 1'b0, 1'b0, 1'b1},
      '{'{REQ_WRITE, 8'h00, 8'h00, 1'b1, 1'b0}, 6'h00, 1'b0, 1'b1, 1'b0},
      '{'{REQ_GEN_READ_TWO, 8'hFF, 8'hFF, 1'b1, 1'b0}, 6'h00, 1'b0, 1'b1, 1'b0},
      '{'{REQ_GEN_READ_ONE, 8'h3C, 8'h99, 1'b0, 1'b1}, DT_GEN_REPLY_ONE, 1'b0, 1'b1, 1'b0}
    };
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge link_clk);
    foreach (rows[i]) begin
      run_row(rows[i]);
      $display("row %0d done", i);
    end
    // A request alone must not draw a reply
    clear();
    b0 = n_bta;
    u_dcps_host_model.send(rows[2].info, 1'b0);
    repeat (40) @(posedge sys_clk);
    compare(q.size() == 0 && n_bta == b0 && lane_owned === 1'b0, "reply without turnaround");
    u_dcps_host_model.turn_bus();
    wait_bta(b0);
    check_row(rows[2]);
    $display("turnaround gating test done");
    // Chained writes before one turnaround draw a single acknowledge
    clear();
    b0 = n_bta;
    u_dcps_host_model.send(rows[0].info, 1'b0);
    u_dcps_host_model.send(rows[0].info, 1'b0);
    u_dcps_host_model.send(rows[0].info, 1'b1);
    wait_bta(b0);
    compare(n_bta == b0 + 1, "one turnaround after burst");
    check_row(rows[0]);
    $display("write burst test done");
    // Reset just after the turnaround is sent, before the device takes the lane
    u_dcps_host_model.send(rows[1].info, 1'b1);
    b0 = n_bta;
    @(posedge sys_clk);
    resetn <= 1'b0;
    repeat (4) @(posedge sys_clk);
    compare(lane_state === LANE_STOP && lane_owned === 1'b0 && pkt_valid === 1'b0 && bta_out === 1'b0,
      "outputs in reset");
    resetn <= 1'b1;
    repeat (30) @(posedge sys_clk);
    compare(n_bta == b0, "reply after reset");
    run_row(rows[2]);
    $display("reset test done");
    end_of_test();
  end
endmodule // tb_top
